// >>> src/sdp_pkg.sv
package sdp_pkg;

    // Array geometry
    localparam int BANKS    = 8;
    localparam int BA_W     = 3;
    localparam int ADDR_W   = 15;
    localparam int DQ_W     = 8;
    localparam int COL_W    = 10;
    localparam int COL_KEEP = 4;
    localparam int MEM_AW   = BA_W + COL_KEEP;
    localparam int BEAT_W   = 3;

    // Address bits with a special meaning on column and precharge commands
    localparam int A_AUTO_PRE  = 10;
    localparam int A_BURST_SEL = 12;

    // Command pin codes {chip select, row strobe, column strobe, write}
    localparam logic [3:0] CODE_ACT = 4'h3;
    localparam logic [3:0] CODE_RD  = 4'h5;
    localparam logic [3:0] CODE_WR  = 4'h4;
    localparam logic [3:0] CODE_PRE = 4'h2;
    localparam logic [3:0] CODE_REF = 4'h1;

    // Burst field of mode_register_zero
    localparam logic [1:0] MR0_BURST_FIXED8 = 2'h0;
    localparam logic [1:0] MR0_BURST_OTF    = 2'h1;
    localparam logic [3:0] BEATS_EIGHT      = 4'h8;
    localparam logic [3:0] BEATS_CHOP       = 4'h4;

    // Timing: least times round up to whole clock cycles
    localparam int CLK_PERIOD_PS          = 10000;
    localparam int PRECHARGE_PERIOD_PS    = 13750;
    localparam int REFRESH_CYCLE_TIME_PS  = 160000;
    localparam int PRE_CYC = (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
    localparam int REF_CYC = (REFRESH_CYCLE_TIME_PS + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
    localparam int PRE_W   = 5;
    localparam int REF_W   = 8;
    localparam int RROW_W  = 15;

    typedef enum logic [2:0]
    {
        CMD_IDLE,
        CMD_ACTIVATE,
        CMD_READ,
        CMD_WRITE,
        CMD_PRECHARGE,
        CMD_REFRESH
    } sdp_cmd_t;

    typedef struct packed
    {
        logic            bad;
        logic [DQ_W-1:0] data;
    } sdp_beat_t;

    typedef struct packed
    {
        logic              valid;
        logic [MEM_AW-1:0] addr;
    } sdp_rdreq_t;

    // Pin pattern to command; unlisted patterns act as no operation
    function automatic sdp_cmd_t sdp_decode(input logic [3:0] pins);
        sdp_cmd_t c;
        unique case (pins)
            CODE_ACT: c = CMD_ACTIVATE;
            CODE_RD:  c = CMD_READ;
            CODE_WR:  c = CMD_WRITE;
            CODE_PRE: c = CMD_PRECHARGE;
            CODE_REF: c = CMD_REFRESH;
            default:  c = CMD_IDLE;
        endcase
        return c;
    endfunction : sdp_decode

endpackage : sdp_pkg

// >>> src/sdp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module sdp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic             ready;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             next_ready;
    logic             push;
    logic             pop;

    // Ready is a flop so the far side sees a clean level
    assign in_ready  = ready;
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && ready;
    assign pop       = out_valid && out_ready;

    // Pointers wrap naturally; depth must be a power of two
    always_comb
    begin
        next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
        next_count  = count + CW'(push) - CW'(pop);
        next_ready  = (next_count != CW'(DEPTH));
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            ready  <= 1'b0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
            ready  <= next_ready;
        end
    end

    // Storage carries no reset
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule : sdp_fifo
`default_nettype wire

// >>> src/sdp_delay.sv
`timescale 1ns/1ns
`default_nettype none
module sdp_delay #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage      [DEPTH];
    logic [WIDTH-1:0] next_stage [DEPTH];

    assign q = stage[DEPTH-1];

    // One register stage per cycle of delay
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_stage
        if (i == 0)
        begin : g_head
            always_comb next_stage[i] = d;
        end
        else
        begin : g_tail
            always_comb next_stage[i] = stage[i-1];
        end

        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                stage[i] <= '0;
            end
            else
            begin
                stage[i] <= next_stage[i];
            end
        end
    end

endmodule : sdp_delay
`default_nettype wire

// >>> src/sdp_core.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Precharge closes one bank or all banks
// - Other banks usable during auto precharge
// - Precharge accepted unless refresh busy; timer restarts
// - Burst select bit picks chop or eight
// - Burst select bit is not column address
// - Eight beats: field 00, or 01 with bit
// - Strobe fault corrupts only addressed data
// - Refresh decoded from low selects, write high
// - Internal counter supplies refresh row address
// - Refresh ends with all banks precharged
// - Bank select lines choose the bank
module sdp_core #(
    parameter int ADDITIVE_LATENCY      = 0,
    parameter int COLUMN_STROBE_LATENCY = 5,
    parameter int FIFO_DEPTH            = 16
) (
    input  wire logic                        CLK,
    input  wire logic                        SYS_RST,
    input  wire logic                        CS_N,
    input  wire logic                        RAS_N,
    input  wire logic                        CAS_N,
    input  wire logic                        WE_N,
    input  wire logic [sdp_pkg::BA_W-1:0]    BA,
    input  wire logic [sdp_pkg::ADDR_W-1:0]  ADDR,
    input  wire logic [1:0]                  MODE_BURST,
    input  wire logic [sdp_pkg::DQ_W-1:0]    WDATA,
    input  wire logic                        WDATA_BAD,
    input  wire logic                        WDATA_VALID,
    output logic                             WDATA_READY,
    output logic      [sdp_pkg::DQ_W-1:0]    RDATA,
    output logic                             RDATA_VALID,
    output logic      [sdp_pkg::BANKS-1:0]   BANK_OPEN,
    output logic      [sdp_pkg::BANKS-1:0]   BANK_IDLE,
    output logic                             REFRESH_BUSY,
    output logic      [sdp_pkg::RROW_W-1:0]  REFRESH_ROW,
    output logic                             CMD_REJECT
);
    localparam int READ_LATENCY = ADDITIVE_LATENCY + COLUMN_STROBE_LATENCY;
    localparam int MEM_WORDS    = 1 << sdp_pkg::MEM_AW;

    sdp_pkg::sdp_cmd_t   cmd;
    sdp_pkg::sdp_beat_t  fifo_in;
    sdp_pkg::sdp_beat_t  fifo_out;
    sdp_pkg::sdp_rdreq_t issue;
    sdp_pkg::sdp_rdreq_t pipe_out;

    logic [sdp_pkg::DQ_W-1:0]     mem [MEM_WORDS];
    logic [sdp_pkg::PRE_W-1:0]    pre_vec [sdp_pkg::BANKS];
    logic [sdp_pkg::BANKS-1:0]    idle_now;
    logic [sdp_pkg::COL_KEEP-1:0] col;
    logic                         eight;
    logic [3:0]                   beats;
    logic                         auto_pre;
    logic                         acc_act;
    logic                         acc_rd;
    logic                         acc_wr;
    logic                         acc_pre;
    logic                         acc_ref;
    logic                         ref_done;
    logic                         next_reject;
    logic [sdp_pkg::REF_W-1:0]    ref_cnt;
    logic [sdp_pkg::REF_W-1:0]    next_ref_cnt;
    logic [sdp_pkg::RROW_W-1:0]   next_ref_row;
    logic [3:0]                   rd_left;
    logic [3:0]                   next_rd_left;
    logic [sdp_pkg::BEAT_W-1:0]   rd_beat;
    logic [sdp_pkg::BEAT_W-1:0]   next_rd_beat;
    logic [sdp_pkg::MEM_AW-1:0]   rd_base;
    logic [sdp_pkg::MEM_AW-1:0]   next_rd_base;
    logic                         rd_chop;
    logic                         next_rd_chop;
    logic [3:0]                   wr_left;
    logic [3:0]                   next_wr_left;
    logic [sdp_pkg::BEAT_W-1:0]   wr_beat;
    logic [sdp_pkg::BEAT_W-1:0]   next_wr_beat;
    logic [sdp_pkg::MEM_AW-1:0]   wr_base;
    logic [sdp_pkg::MEM_AW-1:0]   next_wr_base;
    logic                         wr_chop;
    logic                         next_wr_chop;
    logic                         fifo_valid;
    logic                         take;

    // Address of one beat; a chopped burst wraps inside its four words
    function automatic logic [sdp_pkg::MEM_AW-1:0] beat_addr(
        input logic [sdp_pkg::MEM_AW-1:0] base,
        input logic [sdp_pkg::BEAT_W-1:0] beat,
        input logic                       chop
    );
        logic [sdp_pkg::BEAT_W-1:0] low;
        low = chop ? {base[2], base[1:0] + beat[1:0]} : base[2:0] + beat;
        return {base[sdp_pkg::MEM_AW-1:sdp_pkg::BEAT_W], low};
    endfunction : beat_addr

    // Command decode and acceptance
    assign cmd      = sdp_pkg::sdp_decode({CS_N, RAS_N, CAS_N, WE_N});
    assign col      = ADDR[sdp_pkg::COL_KEEP-1:0];
    assign auto_pre = ADDR[sdp_pkg::A_AUTO_PRE];
    assign eight    = (MODE_BURST == sdp_pkg::MR0_BURST_FIXED8) ||
                      ((MODE_BURST == sdp_pkg::MR0_BURST_OTF) &&
                       ADDR[sdp_pkg::A_BURST_SEL]);
    assign beats    = eight ? sdp_pkg::BEATS_EIGHT : sdp_pkg::BEATS_CHOP;
    assign acc_act  = (cmd == sdp_pkg::CMD_ACTIVATE) && !REFRESH_BUSY &&
                      idle_now[BA];
    // Only the addressed bank matters, so a bank that is auto precharging
    // does not block reads or writes elsewhere
    assign acc_rd   = (cmd == sdp_pkg::CMD_READ) && !REFRESH_BUSY &&
                      BANK_OPEN[BA];
    assign acc_wr   = (cmd == sdp_pkg::CMD_WRITE) && !REFRESH_BUSY &&
                      BANK_OPEN[BA];
    assign acc_pre  = (cmd == sdp_pkg::CMD_PRECHARGE) && !REFRESH_BUSY;
    assign acc_ref  = (cmd == sdp_pkg::CMD_REFRESH) && !REFRESH_BUSY &&
                      (&idle_now);
    assign next_reject = (cmd != sdp_pkg::CMD_IDLE) &&
                         !(acc_act || acc_rd || acc_wr || acc_pre || acc_ref);
    assign ref_done = (ref_cnt == sdp_pkg::REF_W'(1));

    // Per-bank open flag and precharge timer
    for (genvar b = 0; b < sdp_pkg::BANKS; b++)
    begin : g_bank
        logic                      open_q;
        logic                      ready_q;
        logic [sdp_pkg::PRE_W-1:0] pre_q;
        logic                      next_open;
        logic                      next_ready;
        logic [sdp_pkg::PRE_W-1:0] next_pre;
        logic                      hit;

        assign hit = (BA == sdp_pkg::BA_W'(b));

        always_comb
        begin
            next_open = open_q;
            next_pre  = (pre_q != '0) ? pre_q - sdp_pkg::PRE_W'(1) : pre_q;
            if (ref_done)
            begin
                next_open = 1'b0;
                next_pre  = '0;
            end
            else if (acc_act && hit)
            begin
                next_open = 1'b1;
            end
            else if (acc_pre && (auto_pre || hit))
            begin
                next_open = 1'b0;
                next_pre  = sdp_pkg::PRE_W'(sdp_pkg::PRE_CYC);
            end
            else if ((acc_rd || acc_wr) && hit && auto_pre)
            begin
                // Hold the bank through its data beats, then precharge
                next_open = 1'b0;
                next_pre  = sdp_pkg::PRE_W'(sdp_pkg::PRE_CYC) +
                            sdp_pkg::PRE_W'(beats);
            end
            next_ready = !next_open && (next_pre == '0);
        end

        always_ff @(posedge CLK)
        begin
            if (SYS_RST)
            begin
                open_q  <= 1'b0;
                ready_q <= 1'b1;
                pre_q   <= '0;
            end
            else
            begin
                open_q  <= next_open;
                ready_q <= next_ready;
                pre_q   <= next_pre;
            end
        end

        assign BANK_OPEN[b] = open_q;
        assign BANK_IDLE[b] = ready_q;
        assign idle_now[b]  = ready_q;
        assign pre_vec[b]   = pre_q;
    end

    // Refresh timer; the row comes from the internal counter only
    always_comb
    begin
        next_ref_cnt = (ref_cnt != '0) ? ref_cnt - sdp_pkg::REF_W'(1)
                                       : ref_cnt;
        next_ref_row = REFRESH_ROW;
        if (acc_ref)
        begin
            next_ref_cnt = sdp_pkg::REF_W'(sdp_pkg::REF_CYC);
            next_ref_row = REFRESH_ROW + sdp_pkg::RROW_W'(1);
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            ref_cnt      <= '0;
            REFRESH_BUSY <= 1'b0;
            REFRESH_ROW  <= '0;
            CMD_REJECT   <= 1'b0;
        end
        else
        begin
            ref_cnt      <= next_ref_cnt;
            REFRESH_BUSY <= (next_ref_cnt != '0);
            REFRESH_ROW  <= next_ref_row;
            CMD_REJECT   <= next_reject;
        end
    end

    // Read burst: first beat leaves with the command, the rest follow
    always_comb
    begin
        issue        = '0;
        next_rd_left = rd_left;
        next_rd_beat = rd_beat;
        next_rd_base = rd_base;
        next_rd_chop = rd_chop;
        if (acc_rd)
        begin
            next_rd_base = {BA, col};
            next_rd_chop = !eight;
            next_rd_left = beats - 4'h1;
            next_rd_beat = sdp_pkg::BEAT_W'(1);
            issue.valid  = 1'b1;
            issue.addr   = {BA, col};
        end
        else if (rd_left != '0)
        begin
            next_rd_left = rd_left - 4'h1;
            next_rd_beat = rd_beat + sdp_pkg::BEAT_W'(1);
            issue.valid  = 1'b1;
            issue.addr   = beat_addr(rd_base, rd_beat, rd_chop);
        end
    end

    // Write burst: beats drain from the FIFO only while a burst is open
    assign take = fifo_valid && (wr_left != '0);

    always_comb
    begin
        next_wr_left = take ? wr_left - 4'h1 : wr_left;
        next_wr_beat = take ? wr_beat + sdp_pkg::BEAT_W'(1) : wr_beat;
        next_wr_base = wr_base;
        next_wr_chop = wr_chop;
        if (acc_wr)
        begin
            next_wr_base = {BA, col};
            next_wr_chop = !eight;
            next_wr_left = beats;
            next_wr_beat = '0;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            rd_left <= '0;
            rd_beat <= '0;
            rd_base <= '0;
            rd_chop <= 1'b0;
            wr_left <= '0;
            wr_beat <= '0;
            wr_base <= '0;
            wr_chop <= 1'b0;
        end
        else
        begin
            rd_left <= next_rd_left;
            rd_beat <= next_rd_beat;
            rd_base <= next_rd_base;
            rd_chop <= next_rd_chop;
            wr_left <= next_wr_left;
            wr_beat <= next_wr_beat;
            wr_base <= next_wr_base;
            wr_chop <= next_wr_chop;
        end
    end

    // A bad strobe beat spoils its own word only; the burst still ends
    always_ff @(posedge CLK)
    begin
        if (take)
        begin
            mem[beat_addr(wr_base, wr_beat, wr_chop)] <=
                fifo_out.bad ? ~fifo_out.data : fifo_out.data;
        end
    end

    // Array read is the last latency stage
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            RDATA       <= '0;
            RDATA_VALID <= 1'b0;
        end
        else
        begin
            RDATA       <= pipe_out.valid ? mem[pipe_out.addr] : RDATA;
            RDATA_VALID <= pipe_out.valid;
        end
    end

    assign fifo_in.bad  = WDATA_BAD;
    assign fifo_in.data = WDATA;

    sdp_fifo #(
        .WIDTH ($bits(sdp_pkg::sdp_beat_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_wfifo (
        .clk       (CLK),
        .rst       (SYS_RST),
        .in_valid  (WDATA_VALID),
        .in_ready  (WDATA_READY),
        .in_data   (fifo_in),
        .out_valid (fifo_valid),
        .out_ready (wr_left != '0),
        .out_data  (fifo_out)
    );

    sdp_delay #(
        .WIDTH ($bits(sdp_pkg::sdp_rdreq_t)),
        .DEPTH (READ_LATENCY - 1)
    ) u_rdlat (
        .clk (CLK),
        .rst (SYS_RST),
        .d   (issue),
        .q   (pipe_out)
    );

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_pre_one;
        acc_pre && !auto_pre;
    endsequence

    sequence s_rd_go;
        acc_rd;
    endsequence

    bank_close_a: assert property (s_pre_one |=> !BANK_OPEN[$past(BA)])
        else $error("single precharge left bank open");
    all_close_a: assert property (acc_pre && auto_pre |=> BANK_OPEN == '0)
        else $error("all-bank precharge left a bank open");
    pre_time_a: assert property (s_pre_one |=>
        pre_vec[$past(BA)] == sdp_pkg::PRE_W'(sdp_pkg::PRE_CYC))
        else $error("precharge timer not restarted");
    pre_take_a: assert property (
        cmd == sdp_pkg::CMD_PRECHARGE && !REFRESH_BUSY |=> !CMD_REJECT)
        else $error("precharge refused");
    burst_len_a: assert property (s_rd_go |=> rd_left ==
        ($past(eight) ? sdp_pkg::BEATS_EIGHT : sdp_pkg::BEATS_CHOP) - 4'h1)
        else $error("wrong burst length");
    fixed_eight_a: assert property (
        MODE_BURST == sdp_pkg::MR0_BURST_FIXED8 |-> eight)
        else $error("fixed eight mode not honoured");
    col_addr_a: assert property (s_rd_go |-> issue.addr == {BA, col})
        else $error("first beat address wrong");
    read_lat_a: assert property (s_rd_go |-> ##READ_LATENCY RDATA_VALID)
        else $error("read data not at read latency");
    ref_row_a: assert property (acc_ref |=>
        REFRESH_ROW == $past(REFRESH_ROW) + sdp_pkg::RROW_W'(1))
        else $error("refresh row counter did not step");
    ref_idle_a: assert property (ref_done |=>
        BANK_OPEN == '0 && BANK_IDLE == '1 && !REFRESH_BUSY)
        else $error("banks not idle after refresh");
    ref_busy_a: assert property (acc_ref |=> REFRESH_BUSY [*8])
        else $error("refresh cycle ended early");
    drain_go_a: assert property (take && !acc_wr |=>
        wr_left == $past(wr_left) - 4'h1)
        else $error("write burst stalled");

endmodule : sdp_core
`default_nettype wire

// >>> tb/sdp_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// Controller stand-in: one command per call, deselect in between
module sdp_ctrl_model (
    input  wire logic                       CLK,
    output logic                            CS_N,
    output logic                            RAS_N,
    output logic                            CAS_N,
    output logic                            WE_N,
    output logic [sdp_pkg::BA_W-1:0]        BA,
    output logic [sdp_pkg::ADDR_W-1:0]      ADDR,
    output logic [sdp_pkg::DQ_W-1:0]        WDATA,
    output logic                            WDATA_BAD,
    output logic                            WDATA_VALID,
    input  wire logic                       WDATA_READY
);
    // Bus starts deselected with no beat offered
    initial
    begin
        {CS_N, RAS_N, CAS_N, WE_N} = 4'hF;
        BA = 3'h0;
        ADDR = 15'h0000;
        WDATA = 8'h00;
        WDATA_BAD = 1'b0;
        WDATA_VALID = 1'b0;
    end

    // Refresh credit: refreshes issued minus refreshes due, within eight
    localparam int RENEW_CYC = 1000; // average_renewal_interval, plain default
    int ref_credit = 0;
    int renew_cnt  = 0;

    // Watches its own pins, so one process alone owns the credit
    always @(posedge CLK)
    begin
        renew_cnt <= (renew_cnt == RENEW_CYC - 1) ? 0 : renew_cnt + 1;
        if ({CS_N, RAS_N, CAS_N, WE_N} == sdp_pkg::CODE_REF)
        begin
            // Pulling in past eight earns nothing more
            if (ref_credit < 8)
                ref_credit <= ref_credit + 1;
        end
        else if (renew_cnt == RENEW_CYC - 1 && ref_credit > -8)
            ref_credit <= ref_credit - 1;
    end

    // One command for one edge; address then toggles so stale bits are noise
    task automatic cmd(input logic [3:0] code, input logic [2:0] ba,
                       input logic [14:0] addr);
        @(posedge CLK);
        {CS_N, RAS_N, CAS_N, WE_N} <= code;
        BA <= ba;
        ADDR <= addr;
        @(posedge CLK);
        {CS_N, RAS_N, CAS_N, WE_N} <= 4'hF;
        ADDR <= ~addr;
    endtask : cmd

    // Beats held until taken; data line inverted once released
    task automatic burst(input logic [63:0] d, input int n,
                         input logic [7:0] badm);
        @(posedge CLK);
        for (int i = 0; i < n; i++)
        begin
            WDATA <= d[8*(i%8) +: 8];
            WDATA_BAD <= badm[i%8];
            WDATA_VALID <= 1'b1;
            do @(posedge CLK); while (WDATA_READY !== 1'b1);
        end
        WDATA_VALID <= 1'b0;
        WDATA <= ~d[8*((n-1)%8) +: 8];
    endtask : burst
endmodule : sdp_ctrl_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic [1:0]  MODE_BURST = 2'h1;
    logic        CS_N, RAS_N, CAS_N, WE_N, WDATA_BAD, WDATA_VALID;
    logic [2:0]  BA;
    logic [14:0] ADDR, REFRESH_ROW;
    logic [7:0]  WDATA, RDATA, BANK_OPEN, BANK_IDLE;
    logic        WDATA_READY, RDATA_VALID, REFRESH_BUSY, CMD_REJECT;
    int          miscompares = 0;
    int          checked = 0;
    int          rejects = 0;
    int          busy_cyc = 0;
    logic [7:0]  exp_q[$];
    logic [63:0] wd, wc;

    always #5 CLK = ~CLK;

    sdp_core u_dut (.CLK(CLK), .SYS_RST(SYS_RST), .CS_N(CS_N), .RAS_N(RAS_N),
        .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .ADDR(ADDR),
        .MODE_BURST(MODE_BURST), .WDATA(WDATA), .WDATA_BAD(WDATA_BAD),
        .WDATA_VALID(WDATA_VALID), .WDATA_READY(WDATA_READY),
        .RDATA(RDATA), .RDATA_VALID(RDATA_VALID), .BANK_OPEN(BANK_OPEN),
        .BANK_IDLE(BANK_IDLE), .REFRESH_BUSY(REFRESH_BUSY),
        .REFRESH_ROW(REFRESH_ROW), .CMD_REJECT(CMD_REJECT));

    sdp_ctrl_model u_ctrl (.CLK(CLK), .CS_N(CS_N), .RAS_N(RAS_N),
        .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .ADDR(ADDR), .WDATA(WDATA),
        .WDATA_BAD(WDATA_BAD), .WDATA_VALID(WDATA_VALID),
        .WDATA_READY(WDATA_READY));

    task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_data

    task automatic cmp_stat(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_stat

    task automatic test_done();
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    // Read beats take the oldest note; a beat with no note always fails
    always @(posedge CLK)
    begin
        if (RDATA_VALID === 1'b1 && exp_q.size() > 0)
            cmp_data(RDATA, exp_q.pop_front());
        else if (RDATA_VALID === 1'b1)
            cmp_stat(16'h0000, 16'h0001);
        if (CMD_REJECT === 1'b1)
            rejects++;
        if (REFRESH_BUSY === 1'b1)
            busy_cyc++;
    end

    // Whole run is a few hundred cycles; this bound only catches a hang
    initial
    begin
        repeat (4000) @(posedge CLK);
        miscompares++;
        test_done();
    end

    // Note a read's beats, then issue it and let the burst finish
    task automatic rd(input logic [2:0] ba, input logic [14:0] a,
                      input logic [63:0] d, input int n);
        for (int i = 0; i < n; i++)
            exp_q.push_back(d[8*i +: 8]);
        u_ctrl.cmd(sdp_pkg::CODE_RD, ba, a);
        repeat (14) @(posedge CLK);
    endtask : rd

    initial
    begin
        void'($urandom(32'h4cc0e9a6));
        wd = {$urandom, $urandom};
        wc = {$urandom, $urandom};
        repeat (16) @(posedge CLK);
        SYS_RST <= 1'b0;
        repeat (2) @(posedge CLK);
        cmp_stat(16'(BANK_IDLE), 16'h00FF);
        cmp_stat(16'(BANK_OPEN), 16'h0000);
        u_ctrl.cmd(sdp_pkg::CODE_RD, 3'h1, 15'h0000);
        u_ctrl.cmd(sdp_pkg::CODE_ACT, 3'h1, 15'h0000);
        u_ctrl.cmd(sdp_pkg::CODE_ACT, 3'h2, 15'h0000);
        repeat (2) @(posedge CLK);
        cmp_stat(16'(BANK_OPEN), 16'h0006);
        u_ctrl.burst(wd, 8, 8'h00);
        u_ctrl.cmd(sdp_pkg::CODE_WR, 3'h1, 15'h1000);
        u_ctrl.burst(wc, 4, 8'h02);
        // An eight-beat write owns eight cycles before the next write
        @(posedge CLK);
        u_ctrl.cmd(sdp_pkg::CODE_WR, 3'h2, 15'h0000);
        repeat (12) @(posedge CLK);
        // Eight at col 3 wraps in its group of eight
        rd(3'h1, 15'h1003, {wd[23:0], wd[63:24]}, 8);
        rd(3'h1, 15'h0005, {wd[39:32], wd[63:40]}, 4);
        MODE_BURST <= 2'h0;
        rd(3'h1, 15'h0005, {wd[39:0], wd[63:40]}, 8);
        // Other burst field codes chop even with the select bit high
        MODE_BURST <= 2'h2;
        rd(3'h2, 15'h1000, wc ^ 64'h0000_0000_0000_FF00, 4);
        MODE_BURST <= 2'h1;
        u_ctrl.cmd(sdp_pkg::CODE_PRE, 3'h3, 15'h0000);
        u_ctrl.cmd(sdp_pkg::CODE_PRE, 3'h3, 15'h0000);
        u_ctrl.cmd(sdp_pkg::CODE_PRE, 3'h0, 15'h0400);
        repeat (5) @(posedge CLK);
        cmp_stat(16'(BANK_OPEN), 16'h0000);
        cmp_stat(16'(BANK_IDLE), 16'h00FF);
        cmp_stat(16'(rejects), 16'h0001);
        // Refresh with a garbage address, then a command inside it
        u_ctrl.cmd(sdp_pkg::CODE_REF, 3'h5, 15'h7FFF);
        u_ctrl.cmd(sdp_pkg::CODE_ACT, 3'h4, 15'h0000);
        repeat (20) @(posedge CLK);
        cmp_stat(16'(rejects), 16'h0002);
        cmp_stat(16'(REFRESH_ROW), 16'h0001);
        cmp_stat(16'(BANK_IDLE), 16'h00FF);
        u_ctrl.cmd(sdp_pkg::CODE_REF, 3'h0, 15'h0000);
        repeat (20) @(posedge CLK);
        cmp_stat(16'(REFRESH_ROW), 16'h0002);
        cmp_stat(16'(busy_cyc), 16'(2 * sdp_pkg::REF_CYC));
        // Reset in mid run puts the row counter and banks back
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CLK);
        SYS_RST <= 1'b0;
        repeat (2) @(posedge CLK);
        cmp_stat(16'(REFRESH_ROW), 16'h0000);
        cmp_stat(16'(BANK_IDLE), 16'h00FF);
        // Fill the buffer with no write open, then drain it by two writes
        u_ctrl.burst(wd, 16, 8'h00);
        repeat (2) @(posedge CLK);
        cmp_stat(16'(WDATA_READY), 16'h0000);
        u_ctrl.cmd(sdp_pkg::CODE_ACT, 3'h3, 15'h0000);
        u_ctrl.cmd(sdp_pkg::CODE_WR, 3'h3, 15'h1008);
        repeat (8) @(posedge CLK);
        u_ctrl.cmd(sdp_pkg::CODE_WR, 3'h3, 15'h1000);
        repeat (12) @(posedge CLK);
        cmp_stat(16'(WDATA_READY), 16'h0001);
        // Auto precharge closes the bank; its timer runs out by the end
        rd(3'h3, 15'h1408, wd, 8);
        cmp_stat(16'(BANK_OPEN), 16'h0000);
        cmp_stat(16'(BANK_IDLE), 16'h00FF);
        cmp_stat(16'(exp_q.size()), 16'h0000);
        cmp_stat(16'(u_ctrl.ref_credit >= 0), 16'h0001);
        test_done();
    end
endmodule : testbench
`default_nettype wire
